//--- sso_consts.vh
// Constants for the supply supervisor output logic
`ifndef SSO_CONSTS_VH
`define SSO_CONSTS_VH
// ----------------------------------------
// Timebase
// ----------------------------------------
`define SSO_CLK_PERIOD_PS    5000
`define SSO_CLK_PER_MS       200000
// ----------------------------------------
// Power-up hold times, milliseconds, by select code
// ----------------------------------------
`define SSO_PURST_MS_0       50
`define SSO_PURST_MS_1       200
`define SSO_PURST_MS_2       400
`define SSO_PURST_MS_3       800
// ----------------------------------------
// Watchdog timeouts, milliseconds, by select code (3 = off)
// ----------------------------------------
`define SSO_WDT_MS_0         25
`define SSO_WDT_MS_1         200
`define SSO_WDT_MS_2         1400
`define SSO_WDT_OFF          2'h3
// ----------------------------------------
// Counter width, holds the longest count
// ----------------------------------------
`define SSO_CNT_W            32
`endif

//--- sso_bus_watch.v
// Two-wire bus watcher: start, stop and restart pulse for the watchdog
`timescale 1ns/1ps
`default_nettype none
module sso_bus_watch (
  input  wire core_clk,
  input  wire rst_n,
  input  wire scl_in,
  input  wire sda_in,
  input  wire write_protect,
  output reg  wdt_kick,
  output reg  write_req
);
  reg scl_q;
  reg sda_q;
  reg in_frame_q;
  reg fell_q;
  reg [3:0] bitcnt_q;
  reg rw_q;
  wire start_c = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c  = scl_in & scl_q & ~sda_q & sda_in;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      in_frame_q <= 1'b0;
      fell_q     <= 1'b0;
      bitcnt_q   <= 4'h0;
      rw_q       <= 1'b0;
      wdt_kick   <= 1'b0;
      write_req  <= 1'b0;
    end else begin
      // Inputs are never gated, so every edge is seen
      scl_q     <= scl_in; // [RULE_12]
      sda_q     <= sda_in;
      wdt_kick  <= 1'b0;
      write_req <= 1'b0;
      if (start_c) begin
        in_frame_q <= 1'b1;
        fell_q     <= 1'b0;
        bitcnt_q   <= 4'h0;
      end else if (stop_c) begin
        // Start, clock low, clock high, stop restarts the timer
        wdt_kick   <= in_frame_q & fell_q; // [RULE_08] [RULE_14]
        // A write frame is dropped while protection is high
        write_req  <= in_frame_q & ~rw_q & (bitcnt_q > 4'h8) & ~write_protect; // [RULE_11]
        in_frame_q <= 1'b0;
      end else if (in_frame_q && scl_q && !scl_in) begin
        fell_q <= 1'b1;
      end else if (in_frame_q && !scl_q && scl_in) begin
        if (bitcnt_q == 4'h7)
          rw_q <= sda_in;
        if (bitcnt_q != 4'hf)
          bitcnt_q <= bitcnt_q + 4'h1;
      end
    end
  end
endmodule // sso_bus_watch
`default_nettype wire

//--- sso_top.v
// Supply supervisor outputs: fail flags, reset timing and watchdog
// Operation
// [RULE_01] Supply two fail follows its comparator
// [RULE_02] Supply three fail follows its comparator
// [RULE_03] Early low flag follows main comparator
// [RULE_04] Manual reset holds reset plus hold time
// [RULE_05] Active-high variant drives reset push-pull
// [RULE_06] Active-low variant pulls open-drain reset low
// [RULE_07] Power-up keeps reset for hold time
// [RULE_08] Start, clock toggle, stop restarts watchdog
// [RULE_09] No restart within timeout fires watchdog
// [RULE_10] Watchdog output active-low open-drain
// [RULE_11] Write protect rejects all bus writes
// [RULE_12] Data input always observed, never gated
// [RULE_13] Two control bits select watchdog timeout
// [RULE_14] Any read or write restarts watchdog
// [RULE_15] Hold counter restarts on every reset cause
`timescale 1ns/1ps
`default_nettype none
`include "sso_consts.vh"
module sso_top #(
  parameter ACTIVE_HIGH_RST = 0,
  parameter CLK_PER_MS      = `SSO_CLK_PER_MS
) (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       main_supply_ok,
  input  wire       supply2_ok,
  input  wire       supply3_ok,
  input  wire       manual_reset_n,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire       write_protect,
  input  wire [1:0] purst_sel,
  input  wire [1:0] wdt_sel,
  output reg        supply2_fail_n,
  output wire       supply2_fail_oe,
  output reg        supply3_fail_n,
  output wire       supply3_fail_oe,
  output reg        early_low_supply_n,
  output reg        sys_reset_out,
  output wire       sys_reset_oe,
  output reg        watchdog_out_n,
  output wire       watchdog_out_oe,
  output wire       write_req
);
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam [31:0] PU0 = `SSO_PURST_MS_0 * CLK_PER_MS;
  localparam [31:0] PU1 = `SSO_PURST_MS_1 * CLK_PER_MS;
  localparam [31:0] PU2 = `SSO_PURST_MS_2 * CLK_PER_MS;
  localparam [31:0] PU3 = `SSO_PURST_MS_3 * CLK_PER_MS;
  localparam [31:0] WD0 = `SSO_WDT_MS_0 * CLK_PER_MS;
  localparam [31:0] WD1 = `SSO_WDT_MS_1 * CLK_PER_MS;
  localparam [31:0] WD2 = `SSO_WDT_MS_2 * CLK_PER_MS;

  // ----------------------------------------
  // State and next values
  // ----------------------------------------
  localparam [1:0] WD_HOLD  = 2'h0;
  localparam [1:0] WD_RUN   = 2'h1;
  localparam [1:0] WD_FIRED = 2'h2;

  reg  [`SSO_CNT_W-1:0] hold_q;
  reg  [`SSO_CNT_W-1:0] hold_d;
  reg                   rst_act_q;
  reg                   rst_act_d;
  reg  [`SSO_CNT_W-1:0] wdt_q;
  reg  [`SSO_CNT_W-1:0] wdt_d;
  reg  [1:0]            wd_state_q;
  reg  [1:0]            wd_state_d;
  reg  [`SSO_CNT_W-1:0] hold_lim;
  reg  [`SSO_CNT_W-1:0] wdt_lim;
  reg  [2:0]            flag_q;
  wire [2:0]            cmp_ok;
  wire [`SSO_CNT_W-1:0] hold_nxt;
  wire [`SSO_CNT_W-1:0] wdt_nxt;
  wire                  hold_done;
  wire                  wdt_done;
  wire                  wdt_off;
  wire                  kick;
  wire                  cause;

  assign cmp_ok    = {main_supply_ok, supply2_ok, supply3_ok};
  assign hold_nxt  = hold_q + 32'h1;
  assign wdt_nxt   = wdt_q + 32'h1;
  assign hold_done = (hold_nxt >= hold_lim);
  assign wdt_done  = (wdt_nxt >= wdt_lim);
  assign wdt_off   = (wdt_sel == `SSO_WDT_OFF);
  // Either cause restarts the hold count from zero
  assign cause     = ~main_supply_ok | ~manual_reset_n;

  sso_bus_watch u_watch (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .scl_in        (scl_in),
    .sda_in        (sda_in),
    .write_protect (write_protect),
    .wdt_kick      (kick),
    .write_req     (write_req)
  );

  // ----------------------------------------
  // Hold time select
  // ----------------------------------------
  always @* begin
    case (purst_sel)
      2'h0:    hold_lim = PU0;
      2'h1:    hold_lim = PU1;
      2'h2:    hold_lim = PU2;
      default: hold_lim = PU3;
    endcase
  end

  // ----------------------------------------
  // Watchdog timeout select
  // ----------------------------------------
  always @* begin
    case (wdt_sel) // [RULE_13]
      2'h0:    wdt_lim = WD0;
      2'h1:    wdt_lim = WD1;
      default: wdt_lim = WD2;
    endcase
  end

  // ----------------------------------------
  // Supply flags
  // ----------------------------------------
  // Flags come out of flops, one cycle behind the comparators, no hold time
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
          flag_q[gi] <= 1'b0;
        else
          flag_q[gi] <= cmp_ok[gi];
      end
    end
  endgenerate

  always @* begin
    supply3_fail_n     = flag_q[0]; // [RULE_02]
    supply2_fail_n     = flag_q[1]; // [RULE_01]
    early_low_supply_n = flag_q[2]; // [RULE_03]
  end
  assign supply2_fail_oe = ~flag_q[1];
  assign supply3_fail_oe = ~flag_q[0];

  // ----------------------------------------
  // Reset hold
  // ----------------------------------------
  always @* begin
    hold_d    = hold_q;
    rst_act_d = rst_act_q;
    if (cause) begin
      hold_d    = {`SSO_CNT_W{1'b0}}; // [RULE_15]
      rst_act_d = 1'b1; // [RULE_04]
    end else if (rst_act_q) begin
      hold_d = hold_nxt;
      if (hold_done) // [RULE_07]
        rst_act_d = 1'b0;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q    <= {`SSO_CNT_W{1'b0}};
      rst_act_q <= 1'b1;
    end else begin
      hold_q    <= hold_d;
      rst_act_q <= rst_act_d;
    end
  end

  // Active-high variant always drives; active-low variant only sinks
  always @* begin
    sys_reset_out = ACTIVE_HIGH_RST ? rst_act_q : 1'b0; // [RULE_05] [RULE_06]
  end
  assign sys_reset_oe = ACTIVE_HIGH_RST ? 1'b1 : rst_act_q;

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // The timer stays still while system reset is held, so the host boots first
  always @* begin
    wd_state_d = wd_state_q;
    wdt_d      = wdt_q;
    case (wd_state_q)
      WD_HOLD: begin
        wdt_d = {`SSO_CNT_W{1'b0}};
        if (!rst_act_q && !wdt_off)
          wd_state_d = WD_RUN;
      end
      WD_RUN: begin
        if (wdt_done)
          wd_state_d = WD_FIRED; // [RULE_09]
        else
          wdt_d = wdt_nxt;
      end
      WD_FIRED: wd_state_d = WD_FIRED;
      default:  wd_state_d = WD_HOLD;
    endcase
    // Service, reset or disable override every state
    if (kick || rst_act_q || wdt_off) begin
      wd_state_d = WD_HOLD;
      wdt_d      = {`SSO_CNT_W{1'b0}};
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_state_q     <= WD_HOLD;
      wdt_q          <= {`SSO_CNT_W{1'b0}};
      watchdog_out_n <= 1'b1;
    end else begin
      wd_state_q     <= wd_state_d;
      wdt_q          <= wdt_d;
      watchdog_out_n <= (wd_state_d != WD_FIRED); // [RULE_10]
    end
  end
  assign watchdog_out_oe = ~watchdog_out_n; // [RULE_10]
endmodule // sso_top
`default_nettype wire

//--- sso_top_checker.sv
// Checker for the supply supervisor output relations
`timescale 1ns/1ps
`default_nettype none
module sso_top_checker #(parameter CLK_PER_MS = 2) (
  input wire core_clk,
  input wire rst_n,
  input wire main_supply_ok,
  input wire supply2_ok,
  input wire supply3_ok,
  input wire manual_reset_n,
  input wire write_protect,
  input wire supply2_fail_n,
  input wire supply3_fail_n,
  input wire early_low_supply_n,
  input wire sys_reset_oe,
  input wire watchdog_out_oe,
  input wire watchdog_out_n,
  input wire write_req
);
  // Assumes hold select 0; counts edges free of any reset cause
  localparam int HOLD = 50 * CLK_PER_MS;
  logic [15:0] free_q;
  wire cause = !main_supply_ok || !manual_reset_n;
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) free_q <= 16'h0;
    else if (cause) free_q <= 16'h0;
    else if (free_q != 16'hffff) free_q <= free_q + 16'h1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  s2_flag_a: assert property (1 |=> supply2_fail_n == $past(supply2_ok))
    else $error("supply2 flag");
  s3_flag_a: assert property (1 |=> supply3_fail_n == $past(supply3_ok))
    else $error("supply3 flag");
  early_low_a: assert property (1 |=> early_low_supply_n == $past(main_supply_ok))
    else $error("early low flag");
  cause_reset_a: assert property (cause |=> sys_reset_oe)
    else $error("no reset on cause");
  hold_early_a: assert property ($fell(sys_reset_oe) |-> free_q >= HOLD - 1)
    else $error("reset released early");
  hold_late_a: assert property (free_q > HOLD + 2 |-> !sys_reset_oe)
    else $error("reset released late");
  wd_drive_a: assert property (watchdog_out_oe == !watchdog_out_n)
    else $error("watchdog drive");
  wp_block_a: assert property (write_protect |-> !write_req)
    else $error("write not blocked");
  cover property ($fell(sys_reset_oe));
  cover property ($fell(watchdog_out_n));
  cover property ($rose(watchdog_out_n));
  cover property (write_req);
endmodule // sso_top_checker
bind sso_top sso_top_checker #(.CLK_PER_MS(CLK_PER_MS)) u_chk (.*);
`default_nettype wire

//--- sso_host_model.sv
// Host model driving the two-wire lines
`timescale 1ns/1ps
`default_nettype none
module sso_host_model (
  input  wire  core_clk,
  output logic scl = 1'h1,
  output logic sda = 1'h1
);
  task automatic step(input logic c, input logic d);
    repeat (2) @(negedge core_clk);
    scl = c;
    sda = d;
  endtask
  // Shortest service pattern: start, clock low, clock high, stop
  task automatic kick();
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask
  // Full frame: start, address byte with direction, acknowledge bit, stop
  task automatic frame(input logic rw);
    logic [8:0] bits;
    bits = {7'h50, rw, 1'h0};
    step(1'h1, 1'h0);
    for (int i = 8; i >= 0; i--) begin
      step(1'h0, bits[i]);
      step(1'h1, bits[i]);
    end
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask
endmodule // sso_host_model
`default_nettype wire

//--- sso_top_tb_top.sv
// Testbench for the supply supervisor outputs
`timescale 1ns/1ps
`default_nettype none
module sso_top_tb_top;
  localparam int HOLD = 100;
  localparam int WDT = 50;
  logic core_clk = 1'h0, rst_n = 1'h0, main_supply_ok = 1'h1, supply2_ok = 1'h1;
  logic supply3_ok = 1'h1, manual_reset_n = 1'h1, write_protect = 1'h0;
  logic [1:0] purst_sel = 2'h0, wdt_sel = 2'h0;
  wire scl_in, sda_in, supply2_fail_n, supply2_fail_oe, supply3_fail_n, supply3_fail_oe;
  wire early_low_supply_n, sys_reset_out, sys_reset_oe, watchdog_out_n, watchdog_out_oe;
  wire write_req;
  int n_fail = 0, n_compared = 0, cyc = 0, n_wr = 0;
  always #2.5 core_clk = ~core_clk;
  sso_host_model u_host (.core_clk(core_clk), .scl(scl_in), .sda(sda_in));
  sso_top #(.CLK_PER_MS(2)) u_dut (.*);
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset must stay for the whole count, then let go promptly
  task automatic hold_check();
    w(HOLD - 3);
    chk(sys_reset_oe && !sys_reset_out, "reset released early");
    w(6);
    chk(!sys_reset_oe, "reset not released");
  endtask
  task automatic t_flags();
    for (int i = 0; i < 3; i++) begin
      {main_supply_ok, supply2_ok, supply3_ok} = 3'h7 ^ (3'h1 << i);
      w(2);
      chk({early_low_supply_n, supply2_fail_n, supply3_fail_n} === (3'h7 ^ (3'h1 << i)),
          "flag mismatch");
      chk({1'h0, supply2_fail_oe, supply3_fail_oe} === (3'h3 & (3'h1 << i)),
          "fail drive mismatch");
      chk(main_supply_ok || sys_reset_oe, "no reset on low supply");
    end
    {main_supply_ok, supply2_ok, supply3_ok} = 3'h7;
    hold_check();
  endtask
  task automatic t_manual();
    manual_reset_n = 1'h0;
    w(20);
    chk(sys_reset_oe, "no manual reset");
    manual_reset_n = 1'h1;
    hold_check();
  endtask
  // Write protection must not stop the watchdog seeing bus traffic
  task automatic t_watchdog();
    u_host.kick();
    w(WDT - 10);
    chk(watchdog_out_n, "watchdog fired early");
    w(20);
    chk(!watchdog_out_n && watchdog_out_oe, "watchdog silent");
    write_protect = 1'h1;
    u_host.kick();
    w(4);
    chk(watchdog_out_n, "kick ignored");
    write_protect = 1'h0;
  endtask
  // Writes pass unless protected; reads never raise a write
  task automatic t_write();
    int base;
    base = n_wr;
    u_host.frame(1'h0);
    w(3);
    chk(n_wr == base + 1, "write not accepted");
    write_protect = 1'h1;
    u_host.frame(1'h0);
    w(3);
    chk(n_wr == base + 1, "protected write accepted");
    write_protect = 1'h0;
    u_host.frame(1'h1);
    w(3);
    chk(n_wr == base + 1, "read taken as write");
  endtask
  initial begin
    w(4);
    rst_n = 1'h1;
    hold_check();
    t_flags();
    t_manual();
    t_watchdog();
    t_write();
    wrap_up();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (write_req === 1'h1) n_wr <= n_wr + 1;
    if (cyc == 2000) begin
      n_fail++;
      wrap_up();
    end
  end
endmodule // sso_top_tb_top
`default_nettype wire
